/* acs_sequencer.sv */
// Conversion sequencer with Wishbone register interface
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_sequencer #(
  parameter int CLK_PER_MC = `ACS_OSC_PER_IN * `ACS_IN_PER_MC,
  parameter int RES_W      = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              external_start_pin_i,
  input  wire logic [RES_W-1:0]  conv_result_i,
  output logic                   conv_irq_o,
  output logic                   conversion_busy_flag_o,
  output logic                   write_result_cycle_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle boundaries
  logic mc_start;

  acs_cycle_timer #(
    .CLK_PER_MC (CLK_PER_MC)
  ) u_timer (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .mc_start_o (mc_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic               bus_req;
  logic               wr_stb;
  logic               rd_stb;
  logic               conv_clock_divider_select;
  logic               continuous_conversion_bit;
  logic               conversion_done_flag;
  logic               conversion_irq_enable;
  logic               conversion_busy_flag;
  logic [RES_W-1:0]   result_registers;
  logic               done_once;
  logic               pend_trig;
  logic               pin_prev;
  logic               pin_fall;
  logic [4:0]         mc_cnt;
  acs_pkg::acs_state_t state;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // Single-cycle answer: ack in the cycle after the request appears
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb  = bus_req && wb_we_i && wb_sel_i[0];
  assign rd_stb  = bus_req && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_clock_divider_select <= 1'b0;
      continuous_conversion_bit <= 1'b0;
      conversion_irq_enable     <= 1'b0;
    end else if (wr_stb) begin
      if (hit(wb_adr_i, `ACS_OFF_CTRL1)) begin
        conv_clock_divider_select <= wb_dat_i[`ACS_C1_DIV_BIT];
      end
      if (hit(wb_adr_i, `ACS_OFF_CTRL0)) begin
        continuous_conversion_bit <= wb_dat_i[`ACS_C0_CONT_BIT];
      end
      if (hit(wb_adr_i, `ACS_OFF_IRQ_EN)) begin
        conversion_irq_enable <= wb_dat_i[`ACS_IEN_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources, held until the next machine-cycle boundary
  logic write_trig;
  logic cont_rise;
  logic cont_trig;

  assign pin_fall   = pin_prev && !external_start_pin_i;
  assign write_trig = wr_stb && hit(wb_adr_i, `ACS_OFF_RES_LOW);
  assign cont_rise  = wr_stb && hit(wb_adr_i, `ACS_OFF_CTRL0)
                      && wb_dat_i[`ACS_C0_CONT_BIT] && !continuous_conversion_bit;
  // Setting the bit starts only if a conversion ran since reset, else waits
  assign cont_trig  = cont_rise && done_once && (state == acs_pkg::ACS_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= external_start_pin_i;
    end
  end

  // A trigger landing on a boundary clock is kept for the next boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_trig <= 1'b0;
    end else if (write_trig || pin_fall || cont_trig) begin
      pend_trig <= 1'b1;
    end else if (mc_start) begin
      pend_trig <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: conversion length in machine cycles from divider select
  logic [4:0] conv_len;
  logic       conv_end;
  logic       start_now;

  assign conv_len  = conv_clock_divider_select ? 5'(`ACS_MC_DIV8)
                                               : 5'(`ACS_MC_DIV4);
  assign conv_end  = mc_start && (state == acs_pkg::ACS_CONV)
                     && (mc_cnt == conv_len);
  // Pending trigger restarts even a running conversion
  assign start_now = mc_start && pend_trig;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= acs_pkg::ACS_IDLE;
      mc_cnt <= 5'h00;
    end else if (start_now) begin
      state  <= acs_pkg::ACS_CONV;
      mc_cnt <= 5'h01;
    end else if (mc_start) begin
      case (state)
        acs_pkg::ACS_IDLE: begin
          state <= acs_pkg::ACS_IDLE;
        end
        acs_pkg::ACS_CONV: begin
          if (mc_cnt == conv_len) begin
            state <= acs_pkg::ACS_WRITE;
          end else begin
            mc_cnt <= mc_cnt + 5'h01;
          end
        end
        acs_pkg::ACS_WRITE: begin
          // Continuous bit sampled here, so a clear lets this one finish
          if (continuous_conversion_bit) begin
            state  <= acs_pkg::ACS_CONV;
            mc_cnt <= 5'h01;
          end else begin
            state <= acs_pkg::ACS_IDLE;
          end
        end
        default: begin
          state <= acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  // Busy mirrors the converting state: low only in write or idle
  assign conversion_busy_flag   = (state == acs_pkg::ACS_CONV);
  assign conversion_busy_flag_o = conversion_busy_flag;
  assign write_result_cycle_o   = (state == acs_pkg::ACS_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // Result capture at the last boundary of a conversion, even when a restart there skips the write cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_registers <= '0;
    end else if (conv_end) begin
      result_registers <= conv_result_i;
    end
  end

  // Remembers that a conversion completed since reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_once <= 1'b0;
    end else if (conv_end) begin
      done_once <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flag: hardware set wins over a software clear in the same clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_end) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_stb && hit(wb_adr_i, `ACS_OFF_IRQ_REQ)) begin
      conversion_done_flag <= wb_dat_i[`ACS_IRQ_DONE_BIT];
    end
  end

  // Request forwarded to the interrupt system, which adds its own latency
  assign conv_irq_o = conversion_done_flag && conversion_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered with the ack
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `ACS_OFF_CTRL0: begin
        rd_mux[`ACS_C0_CONT_BIT] = continuous_conversion_bit;
        rd_mux[`ACS_C0_BUSY_BIT] = conversion_busy_flag;
      end
      `ACS_OFF_CTRL1: begin
        rd_mux[`ACS_C1_DIV_BIT] = conv_clock_divider_select;
      end
      `ACS_OFF_RES_LOW: begin
        rd_mux[7:6] = result_registers[1:0];
      end
      `ACS_OFF_RES_HIGH: begin
        rd_mux[7:0] = result_registers[RES_W-1:2];
      end
      `ACS_OFF_IRQ_REQ: begin
        rd_mux[`ACS_IRQ_DONE_BIT] = conversion_done_flag;
      end
      `ACS_OFF_IRQ_EN: begin
        rd_mux[`ACS_IEN_EN_BIT] = conversion_irq_enable;
      end
      `ACS_OFF_STATUS: begin
        rd_mux[`ACS_ST_WR_BIT]  = (state == acs_pkg::ACS_WRITE);
        rd_mux[`ACS_ST_STARTED] = done_once;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      wb_dat_o <= rd_mux;
    end
  end
endmodule

/* acs_regs.svh */
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// Word byte addresses on the bus
`define ACS_OFF_CTRL0     8'h00
`define ACS_OFF_CTRL1     8'h04
`define ACS_OFF_RES_LOW   8'h08
`define ACS_OFF_RES_HIGH  8'h0C
`define ACS_OFF_IRQ_REQ   8'h10
`define ACS_OFF_IRQ_EN    8'h14
`define ACS_OFF_STATUS    8'h18

// Control reg0 fields
`define ACS_C0_CONT_BIT   3
`define ACS_C0_BUSY_BIT   4
// Control reg1 fields
`define ACS_C1_DIV_BIT    7
// Irq request / enable fields
`define ACS_IRQ_DONE_BIT  0
`define ACS_IEN_EN_BIT    0
// Status register fields
`define ACS_ST_WR_BIT     0
`define ACS_ST_STARTED    1

// Reset values
`define ACS_RST_CTRL0     8'h00
`define ACS_RST_CTRL1     8'h00

// Timing: input clock is oscillator / 2, 12 input clocks per machine cycle
`define ACS_OSC_PER_IN    2
`define ACS_IN_PER_MC     12
`define ACS_MC_DIV4       8
`define ACS_MC_DIV8       16

`endif

/* acs_pkg.sv */
// Types of the conversion sequencer
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_CONV,
    ACS_WRITE
  } acs_state_t;
endpackage

/* acs_cycle_timer.sv */
// Machine-cycle boundary generator: one pulse per machine cycle
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_cycle_timer #(
  parameter int CLK_PER_MC = `ACS_OSC_PER_IN * `ACS_IN_PER_MC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      mc_start_o
);
  localparam int CW = $clog2(CLK_PER_MC);
  localparam logic [CW-1:0] LAST = CW'(CLK_PER_MC - 1);

  logic [CW-1:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running count; the system clock stands for the oscillator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  // Pulse marks the first clock of every machine cycle
  assign mc_start_o = (cnt == '0) && !rst_i;
endmodule

/* acs_analog_model.sv */
// Analog front-end stand-in feeding conversion results
`timescale 1ns/100ps
module acs_analog_model (
  input  wire logic       clk_i,
  input  wire logic       write_result_cycle_i,
  output logic      [9:0] result_o
);
  logic wr_q = 1'b0;
  // New level at the first clock of every write cycle, so a stale latch shows up
  always @(posedge clk_i) begin
    wr_q <= write_result_cycle_i;
    if (write_result_cycle_i && !wr_q) begin
      result_o <= result_o + 10'h0C3;
    end
  end
  initial result_o = 10'h2A5;
endmodule

/* acs_sequencer_monitor.sv */
// Port-level checker of the conversion sequencer
`timescale 1ns/100ps
module acs_sequencer_checker #(
  parameter int CLK_PER_MC = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic conv_irq_o,
  input wire logic conversion_busy_flag_o,
  input wire logic write_result_cycle_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int wr_cnt;
  int busy_cnt;
  // Run lengths of write cycle and busy, cleared whenever the level drops
  always_ff @(posedge clk_i) begin
    wr_cnt   <= (rst_i || !write_result_cycle_o) ? 0 : wr_cnt + 1;
    busy_cnt <= (rst_i || !conversion_busy_flag_o) ? 0 : busy_cnt + 1;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_busy_write_excl: assert property (!(conversion_busy_flag_o && write_result_cycle_o))
    else $error("busy high in write cycle");
  a_busy_end_write: assert property ($fell(conversion_busy_flag_o) |-> write_result_cycle_o)
    else $error("busy fell without write cycle");
  a_write_len: assert property ($fell(write_result_cycle_o) |-> wr_cnt == CLK_PER_MC)
    else $error("write cycle not one machine cycle");
  a_busy_len: assert property ($fell(conversion_busy_flag_o) |->
    busy_cnt >= 8 * CLK_PER_MC && busy_cnt % CLK_PER_MC == 0)
    else $error("busy span not whole machine cycles");
  a_conv_to_write: assert property ($rose(write_result_cycle_o) |-> $past(conversion_busy_flag_o))
    else $error("write cycle without conversion");
  // Flag writes land at the edge that raises ack, so ack is seen with the change
  a_irq_sw_clear: assert property ($fell(conv_irq_o) |-> wb_cyc_i && wb_we_i && wb_ack_o)
    else $error("irq dropped by hardware");
  a_irq_set: assert property ($rose(conv_irq_o) |->
    $rose(write_result_cycle_o) || (wb_cyc_i && wb_we_i && wb_ack_o))
    else $error("irq rose without cause");
endmodule
bind acs_sequencer acs_sequencer_checker #(.CLK_PER_MC(CLK_PER_MC)) chk (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .conv_irq_o(conv_irq_o), .write_result_cycle_o(write_result_cycle_o),
  .conversion_busy_flag_o(conversion_busy_flag_o));

/* test_adc_conversion_sequencer.sv */
// Self-checking bench of the conversion sequencer
`timescale 1ns/100ps
`include "acs_regs.svh"
module test_adc_conversion_sequencer;
  localparam int MC = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic        ack, irq, busy, wrc;
  logic [9:0]  res, e;
  int          num_errors = 0, checks_done = 0, n_done = 0;
  acs_analog_model pm (.clk_i(clk_i), .write_result_cycle_i(wrc), .result_o(res));
  acs_sequencer #(.CLK_PER_MC(MC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .external_start_pin_i(pin), .conv_result_i(res),
    .conv_irq_o(irq), .conversion_busy_flag_o(busy), .write_result_cycle_o(wrc));
  always #2.5 clk_i = ~clk_i;
  always @(posedge wrc) n_done++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
    rd = dat_o;
    if (t >= 50) check("ack", 0, 1);
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_lv(logic lv);
    int t;
    t = 0;
    while (busy !== lv && t < 500) begin @(posedge clk_i); t++; end
    check("busy level", busy, lv);
  endtask
  task automatic regs();
    logic [7:0] a[5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1C};
    wb(1, 8'h1C, 32'hFF);
    foreach (a[i]) begin wb(0, a[i], 0); check("reset value", rd, 0); end
  endtask
  // Single conversion by register write or by pin edge
  task automatic conv(logic div, logic by_pin);
    int t;
    wb(1, `ACS_OFF_CTRL1, {24'h0, div, 7'h0});
    wb(1, `ACS_OFF_IRQ_EN, {31'h0, !by_pin});
    if (by_pin) begin
      pin <= 1'b0;
      repeat (2) @(posedge clk_i);
      pin <= 1'b1;
    end else wb(1, `ACS_OFF_RES_LOW, 32'hFF);
    wait_lv(1);
    t = 0;
    while (busy === 1'b1 && t < 200) begin @(posedge clk_i); t++; end
    check("busy span", t, (div ? 16 : 8) * MC);
    check("write cycle", wrc, 1);
    e = 10'h2A5 + 10'(n_done - 1) * 10'h0C3;
    wb(0, `ACS_OFF_RES_HIGH, 0); check("result high", rd, {24'h0, e[9:2]});
    wb(0, `ACS_OFF_RES_LOW, 0); check("result low", rd[7:6], e[1:0]);
    check("irq out", irq, !by_pin);
    wb(0, `ACS_OFF_IRQ_REQ, 0); check("done flag", rd[0], 1);
    wb(1, `ACS_OFF_IRQ_REQ, 0); wb(0, `ACS_OFF_IRQ_REQ, 0); check("done clear", rd[0], 0);
  endtask
  // Retrigger mid-conversion; stored result untouched by the dummy write
  task automatic restart();
    int t;
    wb(1, `ACS_OFF_CTRL1, 0);
    wb(1, `ACS_OFF_RES_LOW, 0);
    wait_lv(1);
    repeat (3 * MC) @(posedge clk_i);
    wb(1, `ACS_OFF_RES_LOW, 32'h5A);
    wb(0, `ACS_OFF_RES_HIGH, 0); check("result kept", rd, {24'h0, e[9:2]});
    t = 3 * MC + 6;
    while (busy === 1'b1 && t < 200) begin @(posedge clk_i); t++; end
    check("restart span", t >= 11 * MC && t < 13 * MC + 6, 1);
  endtask
  task automatic cont();
    wb(1, `ACS_OFF_RES_LOW, 0);
    wait_lv(1);
    wb(1, `ACS_OFF_CTRL0, 32'h08);
    wait_lv(0);
    check("write cycle", wrc, 1);
    repeat (MC) @(posedge clk_i);
    check("next start", busy, 1);
    wb(1, `ACS_OFF_CTRL0, 0);
    wait_lv(0);
    repeat (2 * MC) @(posedge clk_i);
    check("stopped", busy, 0);
    // Setting the bit while idle after a prior conversion starts one at the next machine-cycle boundary
    wb(1, `ACS_OFF_CTRL0, 32'h08);
    wait_lv(1);
    wb(1, `ACS_OFF_CTRL0, 0);
    wait_lv(0);
    repeat (2 * MC) @(posedge clk_i);
    check("drained", busy, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    regs();
    conv(0, 0);
    conv(1, 1);
    restart();
    cont();
    finish_test();
  end
endmodule
